//--- pkg/edgcnt_pkg.sv
// Purpose: shared constants for the edge counter and interrupt block
// Assumes: 125 MHz clock, APB register access with 32-bit data
// Notes: offsets are byte addresses of aligned 32-bit words
package edgcnt_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_SELECT = 8'h00;
    localparam logic [7:0] OFS_EDGE = 8'h04;
    localparam logic [7:0] OFS_ARM = 8'h08;
    localparam logic [7:0] OFS_DISARM = 8'h0c;
    localparam logic [7:0] OFS_PRESET = 8'h10;
    localparam logic [7:0] OFS_PRESET_ZERO = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam logic [7:0] OFS_SERVICE = 8'h1c;
    localparam logic [7:0] OFS_RESET = 8'h20;
    localparam logic [7:0] OFS_ARMED = 8'h24;
    localparam logic [7:0] OFS_PENDING = 8'h28;
    localparam logic [7:0] OFS_INFO = 8'h2c;

    // selector codes: 0..N-1 counters, N..2N-1 events, plus two groups
    localparam int SEL_W = 7;
    localparam logic [6:0] all_counter_channels_selector = 7'h5a;
    localparam logic [6:0] all_event_channels_selector = 7'h5b;
    localparam logic [6:0] SEL_RESET = 7'h00;

    // edge field: bit 0 rising_select, bit 1 falling_select
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;
    localparam logic [1:0] EDGE_RESET = 2'h1;

    // service register fields
    localparam int SVC_VALID_BIT = 31;
    localparam int SVC_EVENT_BIT = 8;
    localparam int SVC_CH_W = 5;

    localparam logic [31:0] COUNT_RESET = 32'h0;
    localparam logic [31:0] PRESET_DEFAULT = 32'h0;
    localparam logic [31:0] COUNT_WRAP_FROM = 32'hffffffff;

    // debounce settling time, least figure of the 100 Hz setting
    localparam int CLK_PERIOD_NS = 8;
    localparam int DEBOUNCE_MIN_NS = 2000000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- design/edgcnt_filter.sv
// Purpose: synchronise and debounce one input, flag its edges
// Assumes: input may bounce; clean level must hold DB_CYC cycles
// Notes: rise_out and fall_out are one-cycle pulses
`timescale 1ns/1ns
module edgcnt_filter #(
    parameter int DB_CYC = edgcnt_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic din_in,
    output logic rise_out,
    output logic fall_out
);
    import edgcnt_pkg::*;

    localparam int CNT_W = $clog2(DB_CYC + 1);

    logic sync0;
    logic sync1;
    logic stable;
    logic [CNT_W-1:0] settle;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            sync0 <= 1'b0;
            sync1 <= 1'b0;
        end else begin
            sync0 <= din_in;
            sync1 <= sync0;
        end
    end

    // a new level is accepted only after it held still for DB_CYC cycles
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            stable <= 1'b0;
            settle <= '0;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            fall_out <= 1'b0;
            if (sync1 == stable) begin
                settle <= '0;
            end else if (settle == CNT_W'(DB_CYC - 1)) begin
                settle <= '0;
                stable <= sync1;
                rise_out <= sync1;
                fall_out <= ~sync1;
            end else begin
                settle <= settle + CNT_W'(1);
            end
        end
    end

endmodule

//--- design/edgcnt_chan.sv
// Purpose: one channel's edge counter, arming and pending interrupts
// Assumes: command strobes are one-cycle pulses from the register file
// Notes: counter and event arming are kept apart on purpose
`timescale 1ns/1ns
module edgcnt_chan (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic rise_in,
    input wire logic fall_in,
    input wire logic edge_wr_in,
    input wire logic [1:0] edge_val_in,
    input wire logic preset_in,
    input wire logic [31:0] preset_val_in,
    input wire logic cnt_arm_in,
    input wire logic cnt_disarm_in,
    input wire logic evt_arm_in,
    input wire logic evt_disarm_in,
    input wire logic cnt_svc_in,
    input wire logic evt_svc_in,
    input wire logic clear_all_in,
    output logic [31:0] count_out,
    output logic cnt_armed_out,
    output logic evt_armed_out,
    output logic cnt_pend_out,
    output logic evt_pend_out
);
    import edgcnt_pkg::*;

    logic [1:0] edge_sel;
    logic step;
    logic wrap;

    assign step = (rise_in & edge_sel[EDGE_RISE_BIT]) | (fall_in & edge_sel[EDGE_FALL_BIT]);
    assign wrap = step & ~preset_in & (count_out == COUNT_WRAP_FROM);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            edge_sel <= EDGE_RESET;
        end else if (edge_wr_in) begin
            edge_sel <= edge_val_in;
        end
    end

    // a host preset beats a coincident edge; the count never stops
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            count_out <= COUNT_RESET;
        end else if (preset_in) begin
            count_out <= preset_val_in;
        end else if (step) begin
            count_out <= count_out + 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in || clear_all_in) begin
            cnt_armed_out <= 1'b0;
        end else if (cnt_svc_in || cnt_disarm_in) begin
            cnt_armed_out <= 1'b0;
        end else if (cnt_arm_in) begin
            cnt_armed_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in || clear_all_in) begin
            evt_armed_out <= 1'b0;
        end else if (evt_svc_in || evt_disarm_in) begin
            evt_armed_out <= 1'b0;
        end else if (evt_arm_in) begin
            evt_armed_out <= 1'b1;
        end
    end

    // pending stays until serviced; the guard stops a second raise
    always_ff @(posedge clk_in) begin
        if (!rst_b_in || clear_all_in) begin
            cnt_pend_out <= 1'b0;
        end else if (wrap && cnt_armed_out && !cnt_pend_out) begin
            cnt_pend_out <= 1'b1;
        end else if (cnt_svc_in) begin
            cnt_pend_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in || clear_all_in) begin
            evt_pend_out <= 1'b0;
        end else if (step && evt_armed_out && !evt_pend_out) begin
            evt_pend_out <= 1'b1;
        end else if (evt_svc_in) begin
            evt_pend_out <= 1'b0;
        end
    end

endmodule

//--- design/edgcnt_top.sv
// Purpose: edge counters with counter and event interrupts, APB slave
// Assumes: inputs synchronous to clk_in; one APB master
// Notes: one wait state on every APB access
//
// Functional notes
// - each channel counts alone; armed wrap from -1 to 0 raises interrupt
// - edge setting picks rising, falling or both input edges
// - selector codes address sixteen or eight counter channels
// - group selector arms counter interrupts on every counter channel
// - counter is signed 32 bits and presettable over its full range
// - preset without a value loads zero
// - counter climbs through max, wraps negative, reaches -1 then 0
// - counter arming removable per channel or all at once
// - counter and event arming of one channel are independent
// - servicing a counter interrupt clears it and disarms the channel
// - counting goes on after the wrap; next edge gives one
// - further edges raise nothing while an interrupt waits for service
// - reset and reset command disarm every channel, both kinds
// - on one channel the counter interrupt is presented before the event
// - lowest numbered interrupting channel is presented first
// - every unserviced interrupt is remembered until serviced
// - eight-channel card: edge to request within fifty milliseconds
// - armed event channel interrupts on first selected edge; group arms all
// - sixteen-channel card, 100 Hz setting: delay from 2 to 6.5 ms
`timescale 1ns/1ns
module edgcnt_top #(
    parameter int NUM_CH = 16,
    parameter int DB_CYC = edgcnt_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [NUM_CH-1:0] din_in,
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic intr_req_out
);
    import edgcnt_pkg::*;

    localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    logic [SEL_W-1:0] sel;
    logic access;
    logic wr_fire;
    logic addr_ok;
    logic [31:0] rd_mux;

    logic [NUM_CH-1:0] cnt_hit;
    logic [NUM_CH-1:0] evt_hit;
    logic [NUM_CH-1:0] preset_hit;
    logic sel_is_cnt;
    logic sel_is_evt;
    logic [CH_W-1:0] sel_ch;

    logic wr_edge;
    logic wr_arm;
    logic wr_disarm;
    logic wr_preset;
    logic wr_preset_zero;
    logic wr_service;
    logic wr_reset;
    logic [31:0] preset_val;

    logic [NUM_CH-1:0] rise;
    logic [NUM_CH-1:0] fall;
    logic [31:0] count [NUM_CH];
    logic [NUM_CH-1:0] cnt_armed;
    logic [NUM_CH-1:0] evt_armed;
    logic [NUM_CH-1:0] cnt_pend;
    logic [NUM_CH-1:0] evt_pend;
    logic [NUM_CH-1:0] cnt_svc;
    logic [NUM_CH-1:0] evt_svc;

    logic pres_valid;
    logic pres_evt;
    logic [SVC_CH_W-1:0] pres_ch;
    logic next_pres_valid;
    logic next_pres_evt;
    logic [SVC_CH_W-1:0] next_pres_ch;

    ////////////////////////////////////////////////////////////////////////
    // apb slave: access phase answers on its second cycle
    assign access = psel_in & penable_in;
    assign wr_fire = access & pready_out & pwrite_in & addr_ok;

    always_comb begin
        case (paddr_in)
            OFS_SELECT, OFS_EDGE, OFS_ARM, OFS_DISARM,
            OFS_PRESET, OFS_PRESET_ZERO, OFS_COUNT, OFS_SERVICE,
            OFS_RESET, OFS_ARMED, OFS_PENDING, OFS_INFO: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pready_out <= 1'b0;
        end else begin
            pready_out <= access & ~pready_out;
        end
    end

    // read data and error are captured in the wait cycle and held with pready
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
        end else if (access && !pready_out) begin
            prdata_out <= pwrite_in ? 32'h0 : rd_mux;
            pslverr_out <= ~addr_ok;
        end else begin
            pslverr_out <= 1'b0;
        end
    end

    assign wr_edge = wr_fire & (paddr_in == OFS_EDGE);
    assign wr_arm = wr_fire & (paddr_in == OFS_ARM);
    assign wr_disarm = wr_fire & (paddr_in == OFS_DISARM);
    assign wr_preset = wr_fire & (paddr_in == OFS_PRESET);
    assign wr_preset_zero = wr_fire & (paddr_in == OFS_PRESET_ZERO);
    assign wr_service = wr_fire & (paddr_in == OFS_SERVICE);
    assign wr_reset = wr_fire & (paddr_in == OFS_RESET);
    assign preset_val = wr_preset_zero ? PRESET_DEFAULT : pwdata_in;

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            sel <= SEL_RESET;
        end else if (wr_fire && paddr_in == OFS_SELECT) begin
            sel <= pwdata_in[SEL_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // selector decode: unknown codes select nothing and are ignored
    assign sel_is_cnt = (sel < SEL_W'(NUM_CH));
    assign sel_is_evt = !sel_is_cnt && (sel < SEL_W'(2 * NUM_CH));
    assign sel_ch = sel_is_cnt ? sel[CH_W-1:0] : CH_W'(sel - SEL_W'(NUM_CH));

    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_dec
            assign cnt_hit[g] = (sel == SEL_W'(g))
                || (sel == all_counter_channels_selector);
            assign evt_hit[g] = (sel == SEL_W'(NUM_CH + g))
                || (sel == all_event_channels_selector);
            assign preset_hit[g] = (sel == SEL_W'(g)) & (wr_preset | wr_preset_zero);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // channels
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
            edgcnt_filter #(
                .DB_CYC(DB_CYC)
            ) u_filter (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .din_in(din_in[g]),
                .rise_out(rise[g]),
                .fall_out(fall[g])
            );

            assign cnt_svc[g] = wr_service & pres_valid & ~pres_evt
                & (pres_ch == SVC_CH_W'(g));
            assign evt_svc[g] = wr_service & pres_valid & pres_evt
                & (pres_ch == SVC_CH_W'(g));

            edgcnt_chan u_chan (
                .clk_in(clk_in),
                .rst_b_in(rst_b_in),
                .rise_in(rise[g]),
                .fall_in(fall[g]),
                .edge_wr_in(wr_edge & (cnt_hit[g] | evt_hit[g])),
                .edge_val_in(pwdata_in[1:0]),
                .preset_in(preset_hit[g]),
                .preset_val_in(preset_val),
                .cnt_arm_in(wr_arm & cnt_hit[g]),
                .cnt_disarm_in(wr_disarm & cnt_hit[g]),
                .evt_arm_in(wr_arm & evt_hit[g]),
                .evt_disarm_in(wr_disarm & evt_hit[g]),
                .cnt_svc_in(cnt_svc[g]),
                .evt_svc_in(evt_svc[g]),
                .clear_all_in(wr_reset),
                .count_out(count[g]),
                .cnt_armed_out(cnt_armed[g]),
                .evt_armed_out(evt_armed[g]),
                .cnt_pend_out(cnt_pend[g]),
                .evt_pend_out(evt_pend[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // priority: scan downward so the lowest channel wins, and within a
    // channel the counter interrupt overrides the event interrupt
    always_comb begin
        next_pres_valid = 1'b0;
        next_pres_evt = 1'b0;
        next_pres_ch = '0;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (evt_pend[i]) begin
                next_pres_valid = 1'b1;
                next_pres_evt = 1'b1;
                next_pres_ch = SVC_CH_W'(i);
            end
            if (cnt_pend[i]) begin
                next_pres_valid = 1'b1;
                next_pres_evt = 1'b0;
                next_pres_ch = SVC_CH_W'(i);
            end
        end
    end

    // the presented interrupt lags the pending record by one cycle; an apb
    // access takes at least two, so a service never hits a stale choice
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            pres_valid <= 1'b0;
            pres_evt <= 1'b0;
            pres_ch <= '0;
            intr_req_out <= 1'b0;
        end else begin
            pres_valid <= next_pres_valid;
            pres_evt <= next_pres_evt;
            pres_ch <= next_pres_ch;
            intr_req_out <= next_pres_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; reads have no side effects on any channel
    always_comb begin
        rd_mux = 32'h0;
        case (paddr_in)
            OFS_SELECT: rd_mux[SEL_W-1:0] = sel;
            OFS_COUNT: begin
                if (sel_is_cnt || sel_is_evt) begin
                    rd_mux = count[sel_ch];
                end
            end
            OFS_SERVICE: begin
                rd_mux[SVC_VALID_BIT] = pres_valid;
                rd_mux[SVC_EVENT_BIT] = pres_evt;
                rd_mux[SVC_CH_W-1:0] = pres_ch;
            end
            OFS_ARMED: begin
                rd_mux[NUM_CH-1:0] = cnt_armed;
                rd_mux[16+NUM_CH-1:16] = evt_armed;
            end
            OFS_PENDING: begin
                rd_mux[NUM_CH-1:0] = cnt_pend;
                rd_mux[16+NUM_CH-1:16] = evt_pend;
            end
            OFS_INFO: rd_mux[7:0] = 8'(NUM_CH);
            default: rd_mux = 32'h0;
        endcase
    end

endmodule

//--- verif/edgcnt_properties.sv
// Purpose: bus timing and interrupt checks at the top ports
// Assumes: one wait state on every access
// Notes: bound to edgcnt_top
`timescale 1ns/1ns
module edgcnt_chk
    import edgcnt_pkg::*;
#(
    parameter int NUM_CH = 16
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic intr_req_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    wire logic done_w = psel_in && penable_in && pready_out;
    // a pending bit can only drop through service or the reset register
    wire logic clr_w = done_w && pwrite_in && (paddr_in == OFS_SERVICE || paddr_in == OFS_RESET);
    ////////////////////////////////////////////////////////////////////////////
    ready_wait_a: assert property ($rose(penable_in) |=> pready_out)
        else $error("ready not one cycle after enable");
    ready_cause_a: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
        else $error("ready without a pending access");
    ready_pulse_a: assert property (pready_out |=> !pready_out)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr_out |-> pready_out)
        else $error("error flag outside ready");
    map_err_a: assert property (done_w && paddr_in[1:0] == 2'h0
        |-> pslverr_out == (paddr_in > OFS_INFO))
        else $error("error flag wrong for address");
    wr_zero_a: assert property (done_w && pwrite_in |-> prdata_out == 32'h0)
        else $error("read data not zero on write");
    info_size_a: assert property (done_w && !pwrite_in && paddr_in == OFS_INFO
        |-> prdata_out[7:0] == 8'(NUM_CH))
        else $error("channel count wrong");
    intr_fall_a: assert property ($fell(intr_req_out) |-> $past(clr_w, 2) || $past(clr_w, 3))
        else $error("interrupt dropped without service");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind edgcnt_top edgcnt_chk #(.NUM_CH(NUM_CH)) chk_u (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .paddr_in(paddr_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .intr_req_out(intr_req_out)
);

//--- verif/edgcnt_host.sv
// Purpose: mainframe side model, a register bus master
// Assumes: slave answers with ready; no answer in 50 cycles is a hang
// Notes: raises hang_out when a wait runs out
`timescale 1ns/1ns
module edgcnt_host (
    input wire logic clk_in,
    input wire logic [31:0] prdata_in,
    input wire logic pready_in,
    input wire logic pslverr_in,
    output logic [7:0] paddr_out,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [31:0] pwdata_out,
    output logic hang_out
);
    initial begin
        paddr_out = 8'h00;
        psel_out = 1'b0;
        penable_out = 1'b0;
        pwrite_out = 1'b0;
        pwdata_out = 32'h0;
        hang_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // request held until ready is seen at an edge; data taken at that edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_out <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out <= wr;
        paddr_out <= a;
        pwdata_out <= wd;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 50);
        rd = prdata_in;
        err = pslverr_in;
        if (pready_in !== 1'b1) begin
            hang_out <= 1'b1;
        end
        psel_out <= 1'b0;
        penable_out <= 1'b0;
    endtask
endmodule

//--- verif/tb_top.sv
// Purpose: self-checking bench for the edge counter block
// Assumes: debounce shortened to 4 cycles
// Notes: input pulses are held long enough to pass the filter
`timescale 1ns/1ns
module tb_top;
    import edgcnt_pkg::*;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [15:0] din = 16'h0;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic intr;
    logic hang;
    int n_errors = 0;
    int n_checks = 0;
    localparam logic [31:0] SVC_ORDER [4] = '{32'h80000002, 32'h80000102,
                                              32'h80000009, 32'h80000109};
    always #4 clk_in = ~clk_in;
    edgcnt_top #(.NUM_CH(16), .DB_CYC(4)) dut_u (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .din_in(din),
        .paddr_in(paddr),
        .psel_in(psel),
        .penable_in(penable),
        .pwrite_in(pwrite),
        .pwdata_in(pwdata),
        .prdata_out(prdata),
        .pready_out(pready),
        .pslverr_out(pslverr),
        .intr_req_out(intr)
    );
    edgcnt_host host_u (
        .clk_in(clk_in),
        .prdata_in(prdata),
        .pready_in(pready),
        .pslverr_in(pslverr),
        .paddr_out(paddr),
        .psel_out(psel),
        .penable_out(penable),
        .pwrite_out(pwrite),
        .pwdata_out(pwdata),
        .hang_out(hang)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b1, a, d, r, e);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b0, a, 32'h0, r, e);
        chk32(r, exp);
    endtask
    // one high pulse; each level outlasts the filter and the count step
    task automatic pulse(input logic [15:0] m);
        @(posedge clk_in);
        din <= din | m;
        repeat (12) @(posedge clk_in);
        din <= din & ~m;
        repeat (12) @(posedge clk_in);
    endtask
    // edge to request: two sync flops, four filter cycles, step and pending in one, request, sampling edge
    task automatic pulse_lat(input logic [15:0] m);
        int n;
        n = 0;
        @(posedge clk_in);
        din <= din | m;
        do begin
            @(posedge clk_in);
            n++;
        end while (intr !== 1'b1 && n < 20);
        chk32(32'(n), 32'h9);
        repeat (12) @(posedge clk_in);
        din <= din & ~m;
        repeat (12) @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rdchk(OFS_ARMED, 32'h0);
        rdchk(OFS_PENDING, 32'h0);
        rdchk(OFS_INFO, 32'h10);
        host_u.xfer(1'b0, 8'h40, 32'h0, r, e);
        chk_bit(e, 1'b1);
        chk_bit(intr, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_edges();
        logic [31:0] exp;
        exp = 32'h0;
        wr(OFS_SELECT, 32'h3);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_EDGE, 32'(k));
            pulse(16'h0008);
            exp = exp + 32'(k[0]) + 32'(k[1]);
            rdchk(OFS_COUNT, exp);
        end
        // a two-cycle glitch is shorter than the filter and must not count
        din <= din | 16'h0008;
        repeat (2) @(posedge clk_in);
        din <= din & ~16'h0008;
        repeat (12) @(posedge clk_in);
        rdchk(OFS_COUNT, exp);
        wr(OFS_SELECT, 32'h13);
        rdchk(OFS_COUNT, exp);
        wr(OFS_SELECT, 32'h4);
        rdchk(OFS_COUNT, 32'h0);
        $display("test edges done");
    endtask
    task automatic t_wrap();
        wr(OFS_SELECT, 32'h5);
        wr(OFS_EDGE, 32'h1);
        wr(OFS_PRESET, 32'hfffffffe);
        wr(OFS_ARM, 32'h0);
        pulse(16'h0020);
        rdchk(OFS_COUNT, 32'hffffffff);
        chk_bit(intr, 1'b0);
        pulse(16'h0020);
        rdchk(OFS_COUNT, 32'h0);
        chk_bit(intr, 1'b1);
        rdchk(OFS_SERVICE, 32'h80000005);
        pulse(16'h0020);
        rdchk(OFS_COUNT, 32'h1);
        rdchk(OFS_PENDING, 32'h20);
        wr(OFS_SERVICE, 32'h0);
        repeat (3) @(posedge clk_in);
        chk_bit(intr, 1'b0);
        rdchk(OFS_ARMED, 32'h0);
        wr(OFS_ARM, 32'h0);
        wr(OFS_PRESET, 32'hffffffff);
        pulse_lat(16'h0020);
        chk_bit(intr, 1'b1);
        wr(OFS_SERVICE, 32'h0);
        wr(OFS_PRESET, 32'h7fffffff);
        pulse(16'h0020);
        rdchk(OFS_COUNT, 32'h80000000);
        wr(OFS_PRESET_ZERO, 32'h12345678);
        rdchk(OFS_COUNT, 32'h0);
        rdchk(OFS_SELECT, 32'h5);
        wr(OFS_ARM, 32'h0);
        wr(OFS_DISARM, 32'h0);
        rdchk(OFS_ARMED, 32'h0);
        $display("test wrap done");
    endtask
    task automatic t_prio();
        logic [31:0] r;
        logic e;
        wr(OFS_SELECT, 32'(all_counter_channels_selector));
        wr(OFS_EDGE, 32'h1);
        wr(OFS_ARM, 32'h0);
        wr(OFS_SELECT, 32'(all_event_channels_selector));
        wr(OFS_ARM, 32'h0);
        rdchk(OFS_ARMED, 32'hffffffff);
        wr(OFS_DISARM, 32'h0);
        rdchk(OFS_ARMED, 32'h0000ffff);
        wr(OFS_ARM, 32'h0);
        wr(OFS_SELECT, 32'h9);
        wr(OFS_PRESET, 32'hffffffff);
        wr(OFS_SELECT, 32'h2);
        wr(OFS_PRESET, 32'hffffffff);
        pulse(16'h0204);
        rdchk(OFS_PENDING, 32'h02040204);
        for (int i = 0; i < 4; i++) begin
            rdchk(OFS_SERVICE, SVC_ORDER[i]);
            wr(OFS_SERVICE, 32'h0);
        end
        host_u.xfer(1'b0, OFS_SERVICE, 32'h0, r, e);
        chk_bit(r[SVC_VALID_BIT], 1'b0);
        rdchk(OFS_ARMED, 32'hfdfbfdfb);
        wr(OFS_SELECT, 32'(all_counter_channels_selector));
        wr(OFS_DISARM, 32'h0);
        rdchk(OFS_ARMED, 32'hfdfb0000);
        wr(OFS_RESET, 32'h0);
        rdchk(OFS_ARMED, 32'h0);
        // hardware reset in mid-run: arming, selector and counts all return
        wr(OFS_ARM, 32'h0);
        rst_b_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        rst_b_in <= 1'b1;
        rdchk(OFS_ARMED, 32'h0);
        rdchk(OFS_SELECT, 32'h0);
        wr(OFS_SELECT, 32'h3);
        rdchk(OFS_COUNT, 32'h0);
        $display("test priority done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge hang) begin
        n_errors++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_reset();
        t_edges();
        t_wrap();
        t_prio();
        wrap_up();
    end
endmodule
